// [rtl/qip_top.sv]
// Purpose: Quadrature/index encoder emulation and PWM angle output
// Assumes: ANGLE is the internal 14-bit absolute angle, synchronous to CLK
// Notes:   Registers over Avalon-MM, one cycle of waitrequest per access
`timescale 1ns/10ps
`default_nettype none
module qip_top
  import qip_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire logic [ANG_W-1:0] ANGLE,
  input  wire logic [3:0]       AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  input  wire logic [3:0]       AVS_BYTEENABLE,
  output logic [31:0]           AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  output logic                  QUAD_A,
  output logic                  QUAD_B,
  output logic                  QUAD_Z,
  output logic                  PWM_OUT
);
  typedef enum logic [1:0] {QIP_IDLE, QIP_DONE} qip_bus_t;

  qip_bus_t         bus_reg, bus_next;
  logic [9:0]       ppt_reg, ppt_next;
  logic [3:0]       shape_reg, shape_next;
  logic [7:0]       hys_reg, hys_next;
  logic [31:0]      rd_reg, rd_next;
  logic [11:0]      pos_reg, pos_next;    // Quadrature step count, 0..4n-1
  logic [1:0]       ph_reg, ph_next;      // Two-bit binary phase, low bits of the step count
  logic             a_reg, a_next, b_reg, b_next, z_reg, z_next;
  logic [11:0]      edges;
  logic [25:0]      prod;
  logic [13:0]      bnd_lo, bnd_hi;
  logic [7:0]       hys_lsb;
  logic [13:0]      ang_up, ang_dn;
  logic [11:0]      pos_top;
  logic             step_up, step_dn;
  logic             sel;

  assign edges = {ppt_reg, 2'b00} + 12'h3;
  assign pos_top = edges;

  // Edge boundaries: k*16384/(4n); product kept wide
  function automatic logic [13:0] edge_at(input logic [11:0] k, input logic [11:0] e);
    logic [25:0] num;
    num = {k, 14'h0};
    return 14'((num + {14'h0, e}) / ({14'h0, e} + 26'h1) );
  endfunction
  assign prod = 26'h0;
  assign bnd_lo = edge_at(pos_reg, edges);
  assign bnd_hi = edge_at(pos_reg + 12'h1, edges);

  // Hysteresis code to angle LSBs; unknown codes use the default
  always_comb begin
    unique case (hys_reg)
      HYS_C0:  hys_lsb = HYS_L0;
      HYS_C1:  hys_lsb = HYS_L1;
      HYS_C2:  hys_lsb = HYS_L2;
      HYS_C3:  hys_lsb = HYS_L3;
      HYS_C4:  hys_lsb = HYS_L4;
      HYS_C5:  hys_lsb = HYS_L5;
      HYS_C6:  hys_lsb = HYS_L6;
      HYS_C7:  hys_lsb = HYS_L7;
      HYS_C8:  hys_lsb = HYS_L8;
      default: hys_lsb = HYS_L4;
    endcase
  end

  // Distance past each boundary, modulo one turn
  assign ang_up = ANGLE - bnd_hi;
  assign ang_dn = bnd_lo - ANGLE;
  assign step_up = (ang_up[13] == 1'b0) && (ang_up > {6'h0, hys_lsb});
  assign step_dn = (ang_dn[13] == 1'b0) && (ang_dn > {6'h0, hys_lsb}) && !step_up;

  // One step per clock at most: edges never closer than one update
  always_comb begin
    pos_next = pos_reg;
    if (pos_reg > pos_top) begin
      // Count shrank: drop into the last pulse, phase kept so A/B do not jump
      pos_next = {pos_top[11:2], pos_reg[1:0]};
    end else if (step_up) begin
      pos_next = (pos_reg == pos_top) ? 12'h0 : pos_reg + 12'h1;
    end else if (step_dn) begin
      pos_next = (pos_reg == 12'h0) ? pos_top : pos_reg - 12'h1;
    end
    // Phase tied to position, so every edge sits at a fixed angle
    ph_next  = pos_next[1:0];
    // Gray phase: B leads A by a quarter period going up
    a_next = ph_next[1] ^ 1'b0;
    b_next = ph_next[1] ^ ph_next[0];
    // Index window: shape picks which quarter of the zero pulse, and width
    sel = 1'b0;
    unique case (shape_reg[1:0])
      2'h0: sel = (pos_next == pos_top) || (pos_next == 12'h0);
      2'h1: sel = (pos_next == 12'h0);
      2'h2: sel = (pos_next <= 12'h1);
      2'h3: sel = (pos_next <= 12'h3);
    endcase
    z_next = shape_reg[2] ? (sel && !shape_reg[3]) || (pos_next == 12'h0 && shape_reg[3])
                          : sel;
  end

  // Avalon-MM slave: answer one cycle after the request
  always_comb begin
    bus_next   = QIP_IDLE;
    ppt_next   = ppt_reg;
    shape_next = shape_reg;
    hys_next   = hys_reg;
    rd_next    = rd_reg;
    if ((AVS_READ || AVS_WRITE) && bus_reg == QIP_IDLE) begin
      bus_next = QIP_DONE;
      rd_next  = 32'h0;
      unique case (AVS_ADDRESS)
        OFS_CFG_LO: rd_next = {24'h0, ppt_reg[1:0], 2'b00, shape_reg};
        OFS_CFG_HI: rd_next = {24'h0, ppt_reg[9:2]};
        OFS_HYS:    rd_next = {24'h0, hys_reg};
        OFS_STAT:   rd_next = {17'h0, z_reg, b_reg, a_reg, pos_reg[11:0]};
        default:    rd_next = 32'h0;
      endcase
    end
    // Write lands only at the edge where waitrequest is low
    if (AVS_WRITE && bus_reg == QIP_DONE && AVS_BYTEENABLE[0]) begin
      unique case (AVS_ADDRESS)
        OFS_CFG_LO: begin
          ppt_next[1:0] = AVS_WRITEDATA[LO_PPT_POS +: 2];
          shape_next    = AVS_WRITEDATA[LO_SHAPE_POS +: 4];
        end
        OFS_CFG_HI: ppt_next[9:2] = AVS_WRITEDATA[7:0];
        OFS_HYS:    hys_next = AVS_WRITEDATA[7:0];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bus_reg   <= QIP_IDLE;
      ppt_reg   <= PPT_RST;
      shape_reg <= SHAPE_RST;
      hys_reg   <= HYS_RST;
      rd_reg    <= 32'h0;
      pos_reg   <= 12'h0;
      ph_reg    <= 2'h0;
      a_reg     <= 1'b0;
      b_reg     <= 1'b0;
      z_reg     <= 1'b0;
    end else begin
      bus_reg   <= bus_next;
      ppt_reg   <= ppt_next;
      shape_reg <= shape_next;
      hys_reg   <= hys_next;
      rd_reg    <= rd_next;
      pos_reg   <= pos_next;
      ph_reg    <= ph_next;
      a_reg     <= a_next;
      b_reg     <= b_next;
      z_reg     <= z_next;
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && bus_reg == QIP_IDLE;
  assign AVS_READDATA    = rd_reg;
  assign QUAD_A          = a_reg;
  assign QUAD_B          = b_reg;
  assign QUAD_Z          = z_reg;

  qip_pwm u_pwm (
    .clk   (CLK),
    .rst   (SYS_RST),
    .angle (ANGLE),
    .pwm   (PWM_OUT)
  );

  property p_one_edge;
    @(posedge CLK) disable iff (SYS_RST) !($changed(a_reg) && $changed(b_reg));
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("A and B moved together");
  property p_quad;
    @(posedge CLK) disable iff (SYS_RST) (a_reg ^ b_reg) == (ph_reg[0]);
  endproperty
  a_quad: assert property (p_quad) else $error("quadrature phase broken");
  property p_rst_ppt;
    @(posedge CLK) $fell(SYS_RST) |-> ppt_reg == 10'h3ff;
  endproperty
  a_rst_ppt: assert property (p_rst_ppt) else $error("pulse count reset wrong");
  property p_z_zero;
    @(posedge CLK) disable iff (SYS_RST) z_reg |-> (pos_reg <= 12'h3 || pos_reg == pos_top);
  endproperty
  a_z_zero: assert property (p_z_zero) else $error("index away from zero");
  property p_wr_hi;
    @(posedge CLK) disable iff (SYS_RST)
      (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_CFG_HI && AVS_BYTEENABLE[0])
      |=> ppt_reg[9:2] == $past(AVS_WRITEDATA[7:0]);
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("high count write lost");
  property p_step;
    @(posedge CLK) disable iff (SYS_RST) $changed(ph_reg) |-> $past(step_up || step_dn);
  endproperty
  a_step: assert property (p_step) else $error("step without hysteresis pass");
  property p_wait;
    @(posedge CLK) disable iff (SYS_RST) (AVS_READ && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest held too long");
  property p_hys_rst;
    @(posedge CLK) $fell(SYS_RST) |-> hys_reg == HYS_RST;
  endproperty
  a_hys_rst: assert property (p_hys_rst) else $error("hysteresis reset wrong");
endmodule
`default_nettype wire

// [rtl/qip_pkg.sv]
// Purpose: Constants for the quadrature, index and PWM angle output block
// Assumes: 25 MHz system clock, 14-bit angle word
// Notes:   Register offsets are word addresses on the Avalon-MM slave
package qip_pkg;
  localparam int          CLK_HZ          = 25000000;
  localparam int          UPD_HZ          = 16000000;
  // Output state updates no faster than 16 MHz: UPD_CYC is 2 clocks, unused; qip_top may step every clock
  localparam int          UPD_CYC         = (CLK_HZ + UPD_HZ - 1) / UPD_HZ - 1 + 1;
  localparam int          ANG_W           = 14;
  localparam logic [3:0]  OFS_CFG_LO      = 4'h4;
  localparam logic [3:0]  OFS_CFG_HI      = 4'h5;
  localparam logic [3:0]  OFS_HYS         = 4'h8;
  localparam logic [3:0]  OFS_STAT        = 4'hc;
  localparam logic [9:0]  PPT_RST         = 10'h3ff;
  localparam logic [3:0]  SHAPE_RST       = 4'h0;
  localparam logic [7:0]  HYS_RST         = 8'h9c;
  localparam int          LO_PPT_POS      = 6;
  localparam int          LO_SHAPE_POS    = 0;
  // Hysteresis in angle LSBs, indexed by code group
  localparam logic [7:0]  HYS_C0 = 8'hc8, HYS_C1 = 8'hbc, HYS_C2 = 8'h94;
  localparam logic [7:0]  HYS_C3 = 8'h98, HYS_C4 = 8'h9c, HYS_C5 = 8'h74;
  localparam logic [7:0]  HYS_C6 = 8'h78, HYS_C7 = 8'h7c, HYS_C8 = 8'h54;
  localparam logic [7:0]  HYS_L0 = 8'h04, HYS_L1 = 8'h06, HYS_L2 = 8'h08;
  localparam logic [7:0]  HYS_L3 = 8'h10, HYS_L4 = 8'h18, HYS_L5 = 8'h20;
  localparam logic [7:0]  HYS_L6 = 8'h40, HYS_L7 = 8'h60, HYS_L8 = 8'h80;
  localparam int          PWM_STEPS       = 514;
  localparam int          PWM_SUB         = 32;
  localparam logic [14:0] PWM_LEAD        = 15'h0020;
  localparam logic [14:0] PWM_PERIOD      = 15'h4040;
endpackage

// [rtl/qip_pwm.sv]
// Purpose: Angle-proportional PWM generator
// Assumes: Angle word sampled once at the start of each period
// Notes:   Period is 514*32 clocks; high time is 32 + angle clocks
`timescale 1ns/10ps
`default_nettype none
module qip_pwm
  import qip_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [ANG_W-1:0] angle,
  output logic                  pwm
);
  logic [14:0]      cnt_reg, cnt_next;
  logic [14:0]      hi_reg, hi_next;
  logic             pwm_reg, pwm_next;

  // Period counter; duty spans 1/514 at zero to 513/514 at full scale
  always_comb begin
    cnt_next = (cnt_reg == PWM_PERIOD - 15'h1) ? 15'h0 : cnt_reg + 15'h1;
    hi_next  = (cnt_reg == PWM_PERIOD - 15'h1) ? PWM_LEAD + {1'b0, angle} : hi_reg;
    pwm_next = (cnt_next < hi_next);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 15'h0;
      hi_reg  <= PWM_LEAD;
      pwm_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      hi_reg  <= hi_next;
      pwm_reg <= pwm_next;
    end
  end
  assign pwm = pwm_reg;

  property p_pwm_min;
    @(posedge clk) disable iff (rst) (cnt_reg == 15'h1) |-> pwm_reg;
  endproperty
  a_pwm_min: assert property (p_pwm_min) else $error("pwm low inside minimum duty");
  property p_pwm_max;
    @(posedge clk) disable iff (rst) (cnt_reg >= PWM_PERIOD - PWM_LEAD + 15'h1) |-> !pwm_reg;
  endproperty
  a_pwm_max: assert property (p_pwm_max) else $error("pwm high in minimum off time");
endmodule
`default_nettype wire

// [dv/qip_rx_model.sv]
// Purpose: Far-side quadrature counter and PWM capture model
// Assumes: Block outputs sampled on the rising clock edge
// Notes:   Listens only; nothing is driven back into the block
`timescale 1ns/10ps
`default_nettype none
module qip_rx_model (
  input  wire logic  clk,
  input  wire logic  clr,
  input  wire logic  a,
  input  wire logic  b,
  input  wire logic  z,
  input  wire logic  pwm,
  output logic [31:0] pos,
  output logic [31:0] z_rises,
  output logic [31:0] z_on_bfall,
  output logic [31:0] bad,
  output logic [31:0] hi_time,
  output logic [31:0] period,
  output logic [31:0] n_rise
);
  logic [1:0]  g_prev;
  logic        b_prev;
  logic        z_prev;
  logic        p_prev;
  logic [31:0] run;
  wire  [1:0]  g = {a, a ^ b};
  // Gray decode of A/B; a jump of two means an edge was lost
  always @(posedge clk) begin
    g_prev <= g;
    b_prev <= b;
    z_prev <= z;
    p_prev <= pwm;
    run    <= run + 32'd1;
    if (clr) begin
      pos        <= '0;
      z_rises    <= '0;
      z_on_bfall <= '0;
      bad        <= '0;
      n_rise     <= '0;
    end else begin
      if (g - g_prev == 2'd1)
        pos <= pos + 32'd1;
      else if (g - g_prev == 2'd3)
        pos <= pos - 32'd1;
      else if (g - g_prev == 2'd2)
        bad <= bad + 32'd1;
      if (z && !z_prev) begin
        z_rises <= z_rises + 32'd1;
        if (b_prev && !b)
          z_on_bfall <= z_on_bfall + 32'd1;
      end
      // Both high time and period, so clock drift cancels
      if (pwm && !p_prev) begin
        period <= run;
        run    <= 32'd1;
        n_rise <= n_rise + 32'd1;
      end
      if (!pwm && p_prev)
        hi_time <= run;
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: Self-checking bench for the quadrature and PWM angle block
// Assumes: Avalon-MM access with waitrequest, far-side counter model
// Notes:   Angle swept 4 LSB per clock to keep full turns short
`timescale 1ns/10ps
`default_nettype none
module testbench
  import qip_pkg::*;
;
  logic             clk, rst, rd, wr, clr;
  logic [ANG_W-1:0] angle;
  logic [3:0]       addr, be;
  logic [31:0]      wdata, rdata, q;
  logic             a, b, z, pwm, waitreq;
  logic [31:0]      pos, z_rises, z_on_bfall, bad, hi_time, period, n_rise;
  int               n_fail = 0;
  int               compares = 0;

  qip_top i_qip_top (.CLK(clk), .SYS_RST(rst), .ANGLE(angle), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .QUAD_A(a), .QUAD_B(b),
    .QUAD_Z(z), .PWM_OUT(pwm));
  qip_rx_model i_qip_rx_model (.clk(clk), .clr(clr), .a(a), .b(b), .z(z), .pwm(pwm),
    .pos(pos), .z_rises(z_rises), .z_on_bfall(z_on_bfall), .bad(bad),
    .hi_time(hi_time), .period(period), .n_rise(n_rise));

  // Free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [3:0] ad, input logic [7:0] d,
                     input logic [3:0] e, output logic [31:0] r);
    @(posedge clk);
    addr  <= ad;
    wdata <= {24'h0, d};
    be    <= e;
    rd    <= !w;
    wr    <= w;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] ad, input logic [7:0] exp);
    logic [31:0] r;
    acc(1'b0, ad, 8'h00, 4'hf, r);
    check(r, {24'h0, exp});
  endtask

  // One full turn; settle long enough for any position catch-up first
  task automatic turn(input int start, input int step);
    angle <= ANG_W'(start);
    repeat (300) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    for (int i = 1; i <= 4096; i++) begin
      @(posedge clk);
      angle <= ANG_W'(start + i * step);
    end
    repeat (40) @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst   = 1'b1;
    clr   = 1'b1;
    rd    = 1'b0;
    wr    = 1'b0;
    addr  = 4'h0;
    wdata = 32'h0;
    be    = 4'hf;
    angle = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    // First period after reset is short; measure the second one
    wait (n_rise == 32'd2);
    wait (pwm == 1'b0);
    repeat (2) @(posedge clk);
    check(hi_time, 32'(PWM_LEAD));
    angle <= '1;
    wait (n_rise == 32'd3);
    check(period, 32'(PWM_PERIOD));
    wait (pwm == 1'b0);
    repeat (2) @(posedge clk);
    check(hi_time, 32'(PWM_LEAD) + 32'h3fff);
    rchk(OFS_CFG_LO, 8'hc0);
    rchk(OFS_CFG_HI, 8'hff);
    rchk(OFS_HYS, 8'h9c);
    rchk(4'h0, 8'h00);
    // Smallest hysteresis: the model angle carries no noise
    acc(1'b1, OFS_HYS, 8'hc8, 4'hf, q);
    rchk(OFS_HYS, 8'hc8);
    acc(1'b1, OFS_CFG_LO, 8'h00, 4'hf, q);
    acc(1'b1, OFS_CFG_HI, 8'h00, 4'hf, q);
    rchk(OFS_CFG_LO, 8'h00);
    rchk(OFS_CFG_HI, 8'h00);
    // Start 17 LSB past the edge at 8192, clear of the hysteresis, so its lag cancels
    turn(8209, 4);
    check(pos, 32'd4);
    check(z_rises, 32'd1);
    check(z_on_bfall, 32'd1);
    acc(1'b1, OFS_CFG_LO, 8'hc0, 4'hf, q);
    acc(1'b1, OFS_CFG_HI, 8'h1d, 4'hf, q);
    acc(1'b1, OFS_CFG_HI, 8'hff, 4'h0, q);
    rchk(OFS_CFG_HI, 8'h1d);
    turn(8209, 4);
    check(pos, 32'd480);
    check(z_rises, 32'd1);
    turn(8209, -4);
    check(pos, 32'(-480));
    check(z_rises, 32'd1);
    check(bad, 32'd0);
    report_and_stop;
  end

  // Watchdog sized for three PWM periods plus three turns, with margin
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
